/* include/bos_cfg.svh */
// constants for the block output sequencer: offsets, fields, codes, resets
`ifndef BOS_CFG_SVH
`define BOS_CFG_SVH
// register byte offsets
`define BOS_OFF_SRC 8'h00
`define BOS_OFF_CNT 8'h04
`define BOS_OFF_WRD 8'h08
`define BOS_OFF_FLG 8'h0C
`define BOS_OFF_INS 8'h10
`define BOS_OFF_SPC 8'h14
`define BOS_OFF_STA 8'h18
`define BOS_OFF_SAV 8'h1C
// instruction encodings
`define BOS_PREFIX 8'hED
`define BOS_OPC_DN_SGL 8'h8B
`define BOS_OPC_DN_RPT 8'h9B
`define BOS_OPC_EXT_BYTE 8'hBB
`define BOS_OPC_EXT_WORD 8'hFB
`define BOS_OPC_UP_SGL 8'h83
// flag bit positions
`define BOS_FLG_S 7
`define BOS_FLG_Z 6
`define BOS_FLG_H 4
`define BOS_FLG_P 2
`define BOS_FLG_N 1
`define BOS_FLG_C 0
// status bit positions
`define BOS_STA_BUSY 0
`define BOS_STA_SUSP 1
`define BOS_STA_ILL 2
`define BOS_STA_DONE 3
// reset values and buffer shape
`define BOS_RST_WORD 32'h0000_0000
`define BOS_RST_FLG 8'h00
`define BOS_FIFO_DEPTH 32
`define BOS_FIFO_WIDTH 16
// transfer counts at a zero start count
`define BOS_BYTE_WRAP 17'h0_0100
`define BOS_WORD_WRAP 17'h1_0000
`endif

/* include/bos_pkg.sv */
// types shared by the block output sequencer modules
package bos_pkg;
   typedef enum logic [2:0] {
      BOS_OP_NONE,
      BOS_OP_DN_SGL,
      BOS_OP_DN_RPT,
      BOS_OP_EXT_BYTE,
      BOS_OP_EXT_WORD,
      BOS_OP_UP_SGL
   } bos_op_type;
endpackage : bos_pkg

/* include/bos_fifo_if.sv */
// valid/ready channel between the sequencer and its data buffer
`timescale 1ns/1ps
interface bos_fifo_if #(parameter int W = 16);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic flush;
   modport fifo (input in_valid, input in_data, input out_ready, input flush,
                 output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready, output flush,
                 input in_ready, input out_valid, input out_data);
endinterface : bos_fifo_if

/* verilog/bos_fifo.sv */
// synchronous fifo with flush, parameterised width and depth
`timescale 1ns/1ps
module bos_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // channel
   bos_fifo_if.fifo ch
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin
         $error("bos_fifo: depth must be a power of two of at least 2");
      end
   end

   // honest full and empty straight from the fill count
   assign ch.in_ready = (cnt_q != DEPTH[AW:0]);
   assign ch.out_valid = (cnt_q != '0);
   assign ch.out_data = mem_q[rd_q];
   assign push = ch.in_valid && ch.in_ready && !ch.flush;
   assign pop = ch.out_valid && ch.out_ready && !ch.flush;

   // storage has no reset; only pointers and the fill count carry control state
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= ch.in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (ch.flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   no_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cnt_q <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule : bos_fifo

/* verilog/bos_seq.sv */
// block output sequencer: decode, fetch through a buffer, port writes
`timescale 1ns/1ps
`include "bos_cfg.svh"
module bos_seq #(
   parameter int FIFO_DEPTH = `BOS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   // memory read port, one read outstanding
   output logic mem_rd_q,
   output logic [31:0] mem_addr_q,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_rvalid,
   // peripheral address and data buses
   output logic [31:0] io_addr_q,
   output logic [15:0] io_data_q,
   output logic io_ext_wr_q,
   output logic io_int_wr_q,
   input wire logic io_ready,
   // interrupt acceptance
   input wire logic irq_pending,
   output logic irq_taken_q,
   // opcode seen by the decoder, for the core
   output bos_pkg::bos_op_type op_q
);
   import bos_pkg::*;

   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("bos_seq: fifo depth below 2");
      end
   end

   bos_fifo_if #(.W(`BOS_FIFO_WIDTH)) fch ();

   bos_fifo #(.W(`BOS_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ch(fch)
   );

   logic [31:0] source_pointer_reg_q;
   logic [31:0] count_port_reg_q;
   logic [31:0] word_port_reg_q;
   logic [7:0] flags_q;
   logic [31:0] start_pc_q;
   logic [31:0] saved_pc_q;
   logic busy_q;
   logic susp_q;
   logic ill_q;
   logic done_q;
   logic outst_q;
   logic [31:0] fetch_ptr_q;
   logic [16:0] fetch_left_q;
   logic flush_q;
   logic start;
   logic ins_wr;
   bos_op_type dec_op;
   logic issue;
   logic pop;
   logic last;
   logic [7:0] b_cur;
   logic [7:0] c_cur;
   logic [8:0] b_dec;
   logic [15:0] w_dec;
   logic [7:0] byte_out;
   logic [16:0] wrap_cnt;

   // opcode decoder; anything else after the prefix is illegal
   always_comb begin
      dec_op = BOS_OP_NONE;
      if (reg_wdata[15:8] == `BOS_PREFIX) begin
         if (reg_wdata[7:0] == `BOS_OPC_DN_SGL) begin
            dec_op = BOS_OP_DN_SGL;
         end else if (reg_wdata[7:0] == `BOS_OPC_DN_RPT) begin
            dec_op = BOS_OP_DN_RPT;
         end else if (reg_wdata[7:0] == `BOS_OPC_EXT_BYTE) begin
            dec_op = BOS_OP_EXT_BYTE;
         end else if (reg_wdata[7:0] == `BOS_OPC_EXT_WORD) begin
            dec_op = BOS_OP_EXT_WORD;
         end else if (reg_wdata[7:0] == `BOS_OPC_UP_SGL) begin
            dec_op = BOS_OP_UP_SGL;
         end
      end
   end

   // an instruction write is ignored, not queued, while a dropped read is still outstanding, so no stale push
   assign ins_wr = reg_wr && (reg_addr == `BOS_OFF_INS) && !busy_q;
   assign start = ins_wr && (dec_op != BOS_OP_NONE) && !outst_q;

   assign b_cur = count_port_reg_q[15:8];
   assign c_cur = count_port_reg_q[7:0];
   assign b_dec = {1'b0, b_cur} - 9'h001;
   assign w_dec = count_port_reg_q[15:0] - 16'h0001;
   assign byte_out = fch.out_data[7:0];

   // zero start count wraps to the full range of the counter
   always_comb begin
      wrap_cnt = 17'h0_0001;
      if (dec_op == BOS_OP_EXT_WORD) begin
         wrap_cnt = (count_port_reg_q[15:0] == 16'h0000) ? `BOS_WORD_WRAP
                    : {1'b0, count_port_reg_q[15:0]};
      end else if (dec_op == BOS_OP_DN_RPT || dec_op == BOS_OP_EXT_BYTE) begin
         wrap_cnt = (b_cur == 8'h00) ? `BOS_BYTE_WRAP : {9'h000, b_cur};
      end
   end

   // fetch side: one read in flight, held off while the buffer is full
   assign issue = busy_q && (fetch_left_q != 17'h0_0000) && !outst_q
                  && fch.in_ready && !flush_q;
   assign fch.in_valid = mem_rvalid && outst_q && busy_q;
   assign fch.in_data = mem_rdata;
   assign fch.flush = flush_q;

   // drain side stalls while an external cycle waits for io_ready
   assign fch.out_ready = busy_q && !(io_ext_wr_q && !io_ready) && !flush_q;
   assign pop = fch.out_valid && fch.out_ready;

   // loop ends when the decremented counter reaches zero
   always_comb begin
      last = 1'b1;
      if (op_q == BOS_OP_DN_RPT || op_q == BOS_OP_EXT_BYTE) begin
         last = (b_dec[7:0] == 8'h00);
      end else if (op_q == BOS_OP_EXT_WORD) begin
         last = (w_dec == 16'h0000);
      end
   end

   // fetch pointer and remaining read count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_ptr_q <= `BOS_RST_WORD;
         fetch_left_q <= 17'h0_0000;
         outst_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_addr_q <= `BOS_RST_WORD;
      end else begin
         mem_rd_q <= issue;
         if (start) begin
            fetch_ptr_q <= source_pointer_reg_q;
            fetch_left_q <= wrap_cnt;
         end else if (issue) begin
            mem_addr_q <= fetch_ptr_q;
            fetch_left_q <= fetch_left_q - 17'h0_0001;
            if (op_q == BOS_OP_UP_SGL) begin
               fetch_ptr_q <= fetch_ptr_q + 32'h0000_0001;
            end else if (op_q == BOS_OP_EXT_WORD) begin
               fetch_ptr_q <= fetch_ptr_q - 32'h0000_0002;
            end else begin
               fetch_ptr_q <= fetch_ptr_q - 32'h0000_0001;
            end
         end
         if (issue) begin
            outst_q <= 1'b1;
         end else if (mem_rvalid) begin
            outst_q <= 1'b0;
         end
      end
   end

   // architectural registers, flags and bus outputs, one step per pop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         source_pointer_reg_q <= `BOS_RST_WORD;
         count_port_reg_q <= `BOS_RST_WORD;
         word_port_reg_q <= `BOS_RST_WORD;
         flags_q <= `BOS_RST_FLG;
         io_addr_q <= `BOS_RST_WORD;
         io_data_q <= 16'h0000;
         io_ext_wr_q <= 1'b0;
         io_int_wr_q <= 1'b0;
      end else begin
         io_int_wr_q <= 1'b0;
         if (io_ext_wr_q && io_ready) begin
            io_ext_wr_q <= 1'b0;
         end
         if (reg_wr && !busy_q) begin
            if (reg_addr == `BOS_OFF_SRC) begin
               source_pointer_reg_q <= reg_wdata;
            end else if (reg_addr == `BOS_OFF_CNT) begin
               count_port_reg_q <= reg_wdata;
            end else if (reg_addr == `BOS_OFF_WRD) begin
               word_port_reg_q <= reg_wdata;
            end else if (reg_addr == `BOS_OFF_FLG) begin
               flags_q <= reg_wdata[7:0];
            end
         end
         if (pop) begin
            case (op_q)
               BOS_OP_DN_SGL, BOS_OP_DN_RPT, BOS_OP_UP_SGL: begin
                  // internal write only, address upper lines forced low
                  io_addr_q <= {24'h00_0000, c_cur};
                  io_data_q <= {8'h00, byte_out};
                  io_int_wr_q <= 1'b1;
                  count_port_reg_q[15:8] <= b_dec[7:0];
                  if (op_q == BOS_OP_UP_SGL) begin
                     count_port_reg_q[7:0] <= c_cur + 8'h01;
                     source_pointer_reg_q <= source_pointer_reg_q + 32'h0000_0001;
                  end else begin
                     count_port_reg_q[7:0] <= c_cur - 8'h01;
                     source_pointer_reg_q <= source_pointer_reg_q - 32'h0000_0001;
                  end
                  flags_q[`BOS_FLG_N] <= byte_out[7];
                  if (op_q != BOS_OP_DN_RPT) begin
                     flags_q[`BOS_FLG_S] <= b_dec[7];
                     flags_q[`BOS_FLG_Z] <= (b_dec[7:0] == 8'h00);
                     flags_q[`BOS_FLG_H] <= (b_cur[3:0] == 4'h0);
                     flags_q[`BOS_FLG_P] <= ~^b_dec[7:0];
                     flags_q[`BOS_FLG_C] <= b_dec[8];
                  end else if (last) begin
                     // repeat form ends with fixed flag values
                     flags_q[`BOS_FLG_S] <= 1'b0;
                     flags_q[`BOS_FLG_Z] <= 1'b1;
                     flags_q[`BOS_FLG_H] <= 1'b0;
                     flags_q[`BOS_FLG_P] <= 1'b1;
                     flags_q[`BOS_FLG_C] <= 1'b0;
                  end
               end
               BOS_OP_EXT_BYTE: begin
                  // counter first, so the new B rides on address bits 15-8
                  count_port_reg_q[15:8] <= b_dec[7:0];
                  io_addr_q <= {count_port_reg_q[31:16], b_dec[7:0], c_cur};
                  io_data_q <= {8'h00, byte_out};
                  io_ext_wr_q <= 1'b1;
                  source_pointer_reg_q <= source_pointer_reg_q - 32'h0000_0001;
                  flags_q[`BOS_FLG_Z] <= (b_dec[7:0] == 8'h00);
                  flags_q[`BOS_FLG_N] <= 1'b1;
               end
               BOS_OP_EXT_WORD: begin
                  count_port_reg_q[15:0] <= w_dec;
                  io_addr_q <= word_port_reg_q;
                  io_data_q <= fch.out_data;
                  io_ext_wr_q <= 1'b1;
                  source_pointer_reg_q <= source_pointer_reg_q - 32'h0000_0002;
                  flags_q[`BOS_FLG_Z] <= (w_dec == 16'h0000);
                  flags_q[`BOS_FLG_N] <= 1'b1;
               end
               default: begin
                  io_int_wr_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // run control: start, completion, suspension on a pending interrupt
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= BOS_OP_NONE;
         busy_q <= 1'b0;
         susp_q <= 1'b0;
         ill_q <= 1'b0;
         done_q <= 1'b0;
         flush_q <= 1'b0;
         irq_taken_q <= 1'b0;
         start_pc_q <= `BOS_RST_WORD;
         saved_pc_q <= `BOS_RST_WORD;
      end else begin
         flush_q <= 1'b0;
         irq_taken_q <= 1'b0;
         if (reg_wr && !busy_q && reg_addr == `BOS_OFF_SPC) begin
            start_pc_q <= reg_wdata;
         end
         if (ins_wr) begin
            ill_q <= (dec_op == BOS_OP_NONE);
         end
         if (start) begin
            op_q <= dec_op;
            busy_q <= 1'b1;
            susp_q <= 1'b0;
            done_q <= 1'b0;
            flush_q <= 1'b1;
         end else if (pop && last) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end else if (pop && irq_pending) begin
            // stop between transfers; registers already hold the resume point
            busy_q <= 1'b0;
            susp_q <= 1'b1;
            saved_pc_q <= start_pc_q;
            flush_q <= 1'b1;
            irq_taken_q <= 1'b1;
         end
      end
   end

   // register read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (reg_addr == `BOS_OFF_SRC) begin
            reg_rdata_q <= source_pointer_reg_q;
         end else if (reg_addr == `BOS_OFF_CNT) begin
            reg_rdata_q <= count_port_reg_q;
         end else if (reg_addr == `BOS_OFF_WRD) begin
            reg_rdata_q <= word_port_reg_q;
         end else if (reg_addr == `BOS_OFF_FLG) begin
            reg_rdata_q <= {24'h00_0000, flags_q};
         end else if (reg_addr == `BOS_OFF_INS) begin
            reg_rdata_q <= {29'h0000_0000, op_q};
         end else if (reg_addr == `BOS_OFF_SPC) begin
            reg_rdata_q <= start_pc_q;
         end else if (reg_addr == `BOS_OFF_STA) begin
            reg_rdata_q <= {28'h000_0000, done_q, ill_q, susp_q, busy_q};
         end else if (reg_addr == `BOS_OFF_SAV) begin
            reg_rdata_q <= saved_pc_q;
         end else begin
            reg_rdata_q <= 32'h0000_0000;
         end
      end else begin
         reg_rdata_q <= 32'h0000_0000;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   onchip_upper_zero_a: assert property (
      io_int_wr_q |-> io_addr_q[31:8] == 24'h00_0000)
      else $error("on-chip write with upper address bits set");
   onchip_no_ext_a: assert property (
      io_int_wr_q |-> !io_ext_wr_q)
      else $error("on-chip write started an external cycle");
   ext_byte_addr_a: assert property (
      io_ext_wr_q && op_q == BOS_OP_EXT_BYTE |-> io_addr_q == count_port_reg_q)
      else $error("external byte address differs from count register");
   word_addr_a: assert property (
      io_ext_wr_q && op_q == BOS_OP_EXT_WORD |-> io_addr_q == word_port_reg_q)
      else $error("word address differs from word port register");
   down_step_a: assert property (
      pop && op_q == BOS_OP_DN_SGL |=> source_pointer_reg_q ==
      $past(source_pointer_reg_q) - 32'h0000_0001 && count_port_reg_q[7:0] ==
      $past(count_port_reg_q[7:0]) - 8'h01)
      else $error("down single step wrong");
   up_step_a: assert property (
      pop && op_q == BOS_OP_UP_SGL |=> source_pointer_reg_q ==
      $past(source_pointer_reg_q) + 32'h0000_0001 && count_port_reg_q[15:8] ==
      $past(count_port_reg_q[15:8]) - 8'h01)
      else $error("up single step wrong");
   word_step_a: assert property (
      pop && op_q == BOS_OP_EXT_WORD |=> source_pointer_reg_q ==
      $past(source_pointer_reg_q) - 32'h0000_0002)
      else $error("word pointer not stepped by two");
   onchip_nflag_a: assert property (
      io_int_wr_q |-> flags_q[`BOS_FLG_N] == io_data_q[7])
      else $error("subtract flag does not follow byte msb");
   ext_zflag_a: assert property (
      io_ext_wr_q && op_q == BOS_OP_EXT_BYTE |-> flags_q[`BOS_FLG_N] &&
      flags_q[`BOS_FLG_Z] == (count_port_reg_q[15:8] == 8'h00))
      else $error("external byte flags wrong");
   loop_stop_a: assert property (
      pop && last |=> !busy_q && done_q)
      else $error("loop did not stop on zero count");
   susp_pc_a: assert property (
      $rose(susp_q) |-> saved_pc_q == start_pc_q && !busy_q)
      else $error("suspension without saved start pc");
   decode_up_a: assert property (
      start && dec_op == BOS_OP_UP_SGL |=> busy_q && op_q == BOS_OP_UP_SGL)
      else $error("up single opcode not started");

   onchip_wr_c: cover property (io_int_wr_q);
   ext_wr_c: cover property (io_ext_wr_q && op_q == BOS_OP_EXT_WORD);
   suspend_c: cover property (irq_taken_q);
   done_c: cover property ($rose(done_q) && op_q == BOS_OP_EXT_BYTE);
endmodule : bos_seq

/* verif/bos_mem_model.sv */
// memory and peripheral stand-in facing the sequencer
`timescale 1ns/1ps
module bos_mem_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // memory side
   input wire logic mem_rd_q,
   input wire logic [31:0] mem_addr_q,
   output logic [15:0] mem_rdata,
   output logic mem_rvalid,
   // peripheral side
   input wire logic io_ext_wr_q,
   output logic io_ready,
   // pace select
   input wire logic slow
);
   logic pend_q;
   logic [1:0] lat_q;
   logic [1:0] tick_q;
   logic [31:0] a_q;
   // one read answered after a short or long wait; data bus wanders when idle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         lat_q <= 2'h0;
         a_q <= 32'h0000_0000;
         mem_rvalid <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_rd_q) begin
            pend_q <= 1'b1;
            a_q <= mem_addr_q;
            lat_q <= slow ? 2'h3 : 2'h0;
         end else if (pend_q && lat_q == 2'h0) begin
            pend_q <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= a_q[15:0] ^ 16'hA55A;
         end else if (pend_q) begin
            lat_q <= lat_q - 2'h1;
         end
      end
   end
   // slow pace accepts one external write in four cycles, so the sequencer must stall
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 2'h0;
      end else begin
         tick_q <= tick_q + 2'h1;
      end
   end
   assign io_ready = io_ext_wr_q && (!slow || tick_q == 2'h3);
endmodule : bos_mem_model

/* verif/block_output_sequencer_tb_top.sv */
// self-checking bench for the block output sequencer
`timescale 1ns/1ps
`include "bos_cfg.svh"
module block_output_sequencer_tb_top;
   import bos_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic irq_pending = 1'b0;
   logic slow = 1'b0;
   logic [31:0] reg_rdata_q, mem_addr_q, io_addr_q, a_first, a_last;
   logic [15:0] mem_rdata, io_data_q, d_last;
   logic mem_rd_q, mem_rvalid, io_ext_wr_q, io_int_wr_q, io_ready, irq_taken_q;
   bos_op_type op_q;
   int errors = 0;
   int n_tests = 0;
   int n_int, n_ext, n_irq, n_bad;
   always #50 ref_clk = ~ref_clk;
   bos_seq uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .mem_rd_q, .mem_addr_q, .mem_rdata, .mem_rvalid, .io_addr_q, .io_data_q,
      .io_ext_wr_q, .io_int_wr_q, .io_ready, .irq_pending, .irq_taken_q, .op_q);
   bos_mem_model mdl (.ref_clk, .rst_n, .mem_rd_q, .mem_addr_q, .mem_rdata, .mem_rvalid,
      .io_ext_wr_q, .io_ready, .slow);
   // watch the port buses; on-chip writes must show a byte address only
   always @(posedge ref_clk) begin
      if (io_int_wr_q === 1'b1 || (io_ext_wr_q === 1'b1 && io_ready === 1'b1)) begin
         if (n_int + n_ext == 0) a_first <= io_addr_q;
         a_last <= io_addr_q;
         d_last <= io_data_q;
      end
      if (io_int_wr_q === 1'b1) n_int <= n_int + 1;
      if (io_int_wr_q === 1'b1 && (io_addr_q[31:8] !== 24'h0 || io_ext_wr_q !== 1'b0))
         n_bad <= n_bad + 1;
      if (io_ext_wr_q === 1'b1 && io_ready === 1'b1) n_ext <= n_ext + 1;
      if (irq_taken_q === 1'b1) n_irq <= n_irq + 1;
   end
   task automatic complete_run();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hFFFF_FFFF);
      logic [31:0] d;
      rd(a, d);
      chk(d & m, e);
   endtask : rchk
   task automatic setup(input logic [31:0] p, input logic [31:0] c);
      wr(`BOS_OFF_SRC, p);
      wr(`BOS_OFF_CNT, c);
      n_int = 0;
      n_ext = 0;
      n_irq = 0;
      n_bad = 0;
   endtask : setup
   // start an instruction and poll status until idle, under a bound
   task automatic run(input logic [7:0] opc, output logic [31:0] st);
      wr(`BOS_OFF_INS, {16'h0000, `BOS_PREFIX, opc});
      // busy drops at the last pop; a last external write may still wait for the peripheral
      for (int i = 0; i < 3000; i++) begin
         rd(`BOS_OFF_STA, st);
         if (st[`BOS_STA_BUSY] === 1'b0 && io_ext_wr_q === 1'b0) break;
      end
      if (st[`BOS_STA_BUSY] !== 1'b0 || io_ext_wr_q !== 1'b0) begin
         errors++;
         complete_run();
      end
   endtask : run
   task automatic t_dn_single();
      logic [31:0] st;
      setup(32'h0000_01C0, 32'h0000_1025);
      run(`BOS_OPC_DN_SGL, st);
      chk({29'h0, op_q}, {29'h0, BOS_OP_DN_SGL});
      chk(n_int, 1);
      chk(n_ext + n_bad, 0);
      chk(a_last, 32'h0000_0025);
      chk(d_last, 16'h009A);
      rchk(`BOS_OFF_CNT, 32'h0000_0F24);
      rchk(`BOS_OFF_SRC, 32'h0000_01BF);
      rchk(`BOS_OFF_FLG, 32'h0000_0016, 32'h0000_00FF);
   endtask : t_dn_single
   task automatic t_up_single();
      logic [31:0] st;
      setup(32'h0000_0200, 32'h0000_0180);
      run(`BOS_OPC_UP_SGL, st);
      chk({29'h0, op_q}, {29'h0, BOS_OP_UP_SGL});
      chk(n_int, 1);
      chk(a_last, 32'h0000_0080);
      chk(d_last, 16'h005A);
      rchk(`BOS_OFF_CNT, 32'h0000_0081);
      rchk(`BOS_OFF_SRC, 32'h0000_0201);
      rchk(`BOS_OFF_FLG, 32'h0000_0044, 32'h0000_00FF);
   endtask : t_up_single
   // zero count wraps to a full 256 byte run
   task automatic t_dn_rpt();
      logic [31:0] st;
      wr(`BOS_OFF_FLG, 32'h0000_0091);
      setup(32'h0000_0500, 32'h0000_0040);
      run(`BOS_OPC_DN_RPT, st);
      chk({29'h0, op_q}, {29'h0, BOS_OP_DN_RPT});
      chk(n_int, 256);
      chk(n_bad + n_ext, 0);
      chk(a_first, 32'h0000_0040);
      chk(a_last, 32'h0000_0041);
      rchk(`BOS_OFF_CNT, 32'h0000_0040);
      rchk(`BOS_OFF_SRC, 32'h0000_0400);
      rchk(`BOS_OFF_FLG, 32'h0000_0044, 32'h0000_00FF);
   endtask : t_dn_rpt
   // external bytes against a slow peripheral; other flags must survive
   task automatic t_ext_byte();
      logic [31:0] st;
      slow <= 1'b1;
      wr(`BOS_OFF_FLG, 32'h0000_0091);
      setup(32'h0000_0300, 32'hAB12_0305);
      run(`BOS_OPC_EXT_BYTE, st);
      slow <= 1'b0;
      chk({29'h0, op_q}, {29'h0, BOS_OP_EXT_BYTE});
      chk(n_ext, 3);
      chk(n_int, 0);
      chk(a_first, 32'hAB12_0205);
      chk(a_last, 32'hAB12_0005);
      chk(d_last, 16'h00A4);
      rchk(`BOS_OFF_SRC, 32'h0000_02FD);
      rchk(`BOS_OFF_CNT, 32'hAB12_0005);
      rchk(`BOS_OFF_FLG, 32'h0000_00D3, 32'h0000_00FF);
   endtask : t_ext_byte
   task automatic t_ext_word();
      logic [31:0] st;
      wr(`BOS_OFF_WRD, 32'hCAFE_0010);
      wr(`BOS_OFF_FLG, 32'h0000_0081);
      setup(32'h0000_0400, 32'h5555_0002);
      run(`BOS_OPC_EXT_WORD, st);
      chk({29'h0, op_q}, {29'h0, BOS_OP_EXT_WORD});
      chk(n_ext, 2);
      chk(a_first, 32'hCAFE_0010);
      chk(a_last, 32'hCAFE_0010);
      chk(d_last, 16'hA6A4);
      rchk(`BOS_OFF_SRC, 32'h0000_03FC);
      rchk(`BOS_OFF_CNT, 32'h5555_0000);
      rchk(`BOS_OFF_FLG, 32'h0000_00C3, 32'h0000_00FF);
   endtask : t_ext_word
   // suspend after one transfer, then resume from the updated pointer and count registers
   task automatic t_irq();
      logic [31:0] st;
      wr(`BOS_OFF_SPC, 32'h0000_1234);
      setup(32'h0000_0600, 32'h0000_0520);
      irq_pending <= 1'b1;
      run(`BOS_OPC_DN_RPT, st);
      irq_pending <= 1'b0;
      chk(st[`BOS_STA_SUSP], 1'b1);
      chk(n_irq, 1);
      chk(n_int, 1);
      rchk(`BOS_OFF_SAV, 32'h0000_1234);
      run(`BOS_OPC_DN_RPT, st);
      chk(n_int, 5);
      rchk(`BOS_OFF_CNT, 32'h0000_001B);
      rchk(`BOS_OFF_SRC, 32'h0000_05FB);
   endtask : t_irq
   task automatic t_illegal();
      logic [31:0] st;
      setup(32'h0000_0100, 32'h0000_0101);
      run(8'h8C, st);
      chk(st[`BOS_STA_ILL], 1'b1);
      chk(n_int + n_ext, 0);
      rchk(8'h20, 32'h0000_0000);
   endtask : t_illegal
   // reset for twenty cycles, then the scenarios in turn
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_dn_single();
      t_up_single();
      t_dn_rpt();
      t_ext_byte();
      t_ext_word();
      t_irq();
      t_illegal();
      complete_run();
   end
endmodule : block_output_sequencer_tb_top
